// ---- cmie_exec.v ----
// Execution of data move, no-op, option load and return from interrupt
// Summary of operation
// - No-op changes no register, flag or memory
// - No-op: one word, one cycle, Q1 decode
// - Option load copies accumulator, flags untouched
// - Option register also directly file addressable
// - Return pops stack, sets irq enable, 2 cycles
`timescale 1ns/1ps
`default_nettype none
`include "cmie_consts.vh"
module cmie_exec #(
    parameter OPC_W = `CMIE_OPC_W,
    parameter DAT_W = `CMIE_DAT_W
) (
    input wire i_mclk,
    input wire i_rst,
    input wire [OPC_W-1:0] i_instr,
    input wire [DAT_W-1:0] i_acc,
    input wire [`CMIE_PC_W-1:0] i_stack_top_entry,
    input wire [DAT_W-1:0] i_irq_control_reg,
    output wire [3:0] o_q,
    output reg o_fetch,
    output reg o_file_we,
    output reg [`CMIE_FA_W-1:0] o_file_addr,
    output reg [DAT_W-1:0] o_file_wdata,
    output reg o_stack_pop,
    output reg o_pc_load,
    output reg [`CMIE_PC_W-1:0] o_pc_value,
    output reg o_irqc_we,
    output reg [DAT_W-1:0] o_irqc_wdata,
    output reg [DAT_W-1:0] o_option,
    output reg o_status_we,
    output reg o_illegal
);
    // ****************************************
    // Timing of one instruction cycle
    // ****************************************
    // One instruction cycle is four clocks, one per quarter phase.
    // Edge at Q1: the offered word is latched into the instruction register.
    // Edge at Q2: nothing happens for the instructions handled here.
    // Edge at Q3: a return writes the control register with its enable set.
    // Edge at Q4: moves, option loads and the stack pop take effect.
    // All strobes are registered, so each one shows for the clock after
    // the edge that launches it and is gone again one clock later.
    // A return owns a second cycle in which the prefetched word is dropped;
    // the fetch request at the end of its first cycle is held back so the
    // program side does not waste a fetch on a word nobody will execute.
    // Limitation: the block trusts the program side to hold the word at the
    // Q1 edge; there is no handshake on the instruction input.

    // ****************************************
    // Phase and decode
    // ****************************************
    // Cycle states, one-hot: a normal execute cycle, or the dead
    // second cycle of a return
    localparam ST_EXEC = 2'b01;
    localparam ST_FLUSH = 2'b10;
    reg [1:0] state_r;
    reg [OPC_W-1:0] ir_r;

    // Quarter phase strobes from the one-hot phase counter
    wire q1 = (o_q == `CMIE_Q1);
    wire q3 = (o_q == `CMIE_Q3);
    wire q4 = (o_q == `CMIE_Q4);
    wire is_execute = (state_r == ST_EXEC);

    // Opcode matches; the no-op ignores its two don't-care bits
    wire dec_move_acc = ((ir_r & `CMIE_MOVE_ACC_MASK) == `CMIE_MOVE_ACC_VAL);
    wire dec_nop = ((ir_r & `CMIE_NOP_MASK) == `CMIE_NOP_VAL);
    wire dec_optld = (ir_r == `CMIE_OPTLD_VAL);
    wire dec_reti = (ir_r == `CMIE_RETI_VAL);
    wire dec_known = dec_move_acc || dec_nop || dec_optld || dec_reti;

    // Qualified action strobes, each gated by the quarter in which its work is done
    wire do_irq_enable = is_execute && q3 && dec_reti;
    wire do_pop = is_execute && q4 && dec_reti;
    wire do_move = is_execute && q4 && dec_move_acc;
    wire do_optld = is_execute && q4 && dec_optld;
    wire do_illegal = is_execute && q4 && !dec_known;
    wire move_hits_option = (ir_r[`CMIE_FA_W-1:0] == `CMIE_OPTION_ADDR);

    // Enable bit mask, built at the data width
    wire [DAT_W-1:0] irq_en_mask = {{(DAT_W-1){1'b0}}, 1'b1} << `CMIE_IRQ_EN_BIT;

    cmie_qgen u_qgen (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .o_q(o_q)
    );

    // ****************************************
    // Instruction register and cycle sequencing
    // ****************************************
    // The state moves only on the Q4 edge, so a cycle never changes
    // its kind half way through its quarters
    always @(posedge i_mclk) begin
        if (i_rst) begin
            state_r <= ST_EXEC;
        end else if (q4) begin
            case (state_r)
                ST_EXEC: begin
                    state_r <= dec_reti ? ST_FLUSH : ST_EXEC;
                end
                ST_FLUSH: begin
                    state_r <= ST_EXEC;
                end
                default: begin
                    state_r <= ST_EXEC;
                end
            endcase
        end
    end

    // Word is latched at Q1; in the flush cycle the prefetched word is
    // replaced by a no-op, so it can never write or flag anything
    always @(posedge i_mclk) begin
        if (i_rst) begin
            ir_r <= {OPC_W{1'b0}};
        end else if (q1) begin
            ir_r <= (state_r == ST_FLUSH) ? `CMIE_NOP_VAL : i_instr;
        end
    end

    // ****************************************
    // Fetch request
    // ****************************************
    // The next word is asked for at the end of each cycle, except at the
    // end of a return's first cycle, whose following word is thrown away
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_fetch <= 1'b0;
        end else begin
            o_fetch <= q4 && !(is_execute && dec_reti);
        end
    end

    // ****************************************
    // File register write
    // ****************************************
    // Strobe is one clock wide; address and data hold until the next move
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_file_we <= 1'b0;
            o_file_addr <= {`CMIE_FA_W{1'b0}};
            o_file_wdata <= {DAT_W{1'b0}};
        end else begin
            o_file_we <= do_move;
            if (do_move) begin
                o_file_addr <= ir_r[`CMIE_FA_W-1:0];
                o_file_wdata <= i_acc;
            end
        end
    end

    // ****************************************
    // Option register
    // ****************************************
    // Two ways in: a move aimed at its file address, or the old dedicated
    // load; both land on Q4 of different words, so they never collide
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_option <= `CMIE_OPTION_RST;
        end else if (do_move && move_hits_option) begin
            o_option <= i_acc;
        end else if (do_optld) begin
            o_option <= i_acc;
        end
    end

    // ****************************************
    // Interrupt control write
    // ****************************************
    // Only the enable bit is set; the other bits are written back as read
    // at Q3, so a flag raised in the same quarter can still be lost
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_irqc_we <= 1'b0;
            o_irqc_wdata <= {DAT_W{1'b0}};
        end else begin
            o_irqc_we <= do_irq_enable;
            if (do_irq_enable) begin
                o_irqc_wdata <= i_irq_control_reg | irq_en_mask;
            end
        end
    end

    // ****************************************
    // Stack pop and program counter load
    // ****************************************
    // Pop and load travel together so the counter never takes a stale top
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_stack_pop <= 1'b0;
            o_pc_load <= 1'b0;
            o_pc_value <= {`CMIE_PC_W{1'b0}};
        end else begin
            o_stack_pop <= do_pop;
            o_pc_load <= do_pop;
            if (do_pop) begin
                o_pc_value <= i_stack_top_entry;
            end
        end
    end

    // ****************************************
    // Status and unknown words
    // ****************************************
    // None of these instructions changes a flag, so the status strobe
    // stays low; unknown words are flagged, never executed
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_status_we <= 1'b0;
            o_illegal <= 1'b0;
        end else begin
            o_status_we <= 1'b0;
            o_illegal <= do_illegal;
        end
    end
endmodule // cmie_exec
`default_nettype wire

// ---- cmie_consts.vh ----
// Constants for the miscellaneous instruction execution block
`ifndef CMIE_CONSTS_VH
`define CMIE_CONSTS_VH
`define CMIE_OPC_W 14
`define CMIE_DAT_W 8
`define CMIE_FA_W 7
`define CMIE_PC_W 13
`define CMIE_MOVE_ACC_MASK 14'h3F80
`define CMIE_MOVE_ACC_VAL 14'h0080
`define CMIE_NOP_MASK 14'h3F9F
`define CMIE_NOP_VAL 14'h0000
`define CMIE_OPTLD_VAL 14'h0062
`define CMIE_RETI_VAL 14'h0009
`define CMIE_OPTION_ADDR 7'h01
`define CMIE_OPTION_RST 8'hFF
`define CMIE_IRQ_EN_BIT 7
`define CMIE_Q1 4'h1
`define CMIE_Q2 4'h2
`define CMIE_Q3 4'h4
`define CMIE_Q4 4'h8
`endif

// ---- cmie_qgen.v ----
// Quarter phase generator for the instruction cycle
`timescale 1ns/1ps
`default_nettype none
module cmie_qgen (
    input wire i_mclk,
    input wire i_rst,
    output reg [3:0] o_q
);
    // One-hot rotation Q1..Q4, one quarter per clock
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_q <= 4'h1;
        end else begin
            o_q <= {o_q[2:0], o_q[3]};
        end
    end
endmodule // cmie_qgen
`default_nettype wire

// ---- cmie_exec_monitor.sv ----
// Assertion checker for the instruction execution block
`timescale 1ns/1ps
`default_nettype none
module cmie_exec_monitor (
    input wire i_mclk,
    input wire i_rst,
    input wire [13:0] i_instr,
    input wire [7:0] i_acc,
    input wire [3:0] o_q,
    input wire o_fetch,
    input wire o_file_we,
    input wire [7:0] o_file_wdata,
    input wire o_stack_pop,
    input wire o_pc_load,
    input wire o_irqc_we,
    input wire [7:0] o_irqc_wdata,
    input wire [7:0] o_option
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // Word taken at Q1, matched at its Q4 edge; a word offered in a return's
    // flush cycle is not fetched and so does not count
    sequence s_run(w);
        ((o_q == 4'h1) && (o_fetch || $past(i_rst)) && w) ##3 1;
    endsequence
    a_quarter_walk: assert property (o_q == 4'h1 |=> o_q == 4'h2 ##1 o_q == 4'h4 ##1 o_q == 4'h8)
        else $error("quarter phase order broken");
    a_nop_quiet: assert property (s_run((i_instr & 14'h3F9F) == 0) |=> !o_file_we && !o_irqc_we && $stable(o_option))
        else $error("no-op changed state");
    a_option_load: assert property (s_run(i_instr == 14'h0062) |=> o_option == $past(i_acc))
        else $error("option load lost accumulator");
    a_direct_option: assert property (s_run(i_instr == 14'h0081) |=> o_option == $past(i_acc))
        else $error("direct option write lost");
    a_move_write: assert property (s_run(i_instr[13:7] == 7'h01) |=> o_file_we && o_file_wdata == $past(i_acc))
        else $error("file write missing");
    a_return_pop: assert property (s_run(i_instr == 14'h0009) |-> o_irqc_we && o_irqc_wdata[7] ##1 o_stack_pop && o_pc_load)
        else $error("return sequence broken");
    a_return_nofetch: assert property (s_run(i_instr == 14'h0009) |=> !o_fetch ##4 o_fetch)
        else $error("return fetch timing broken");
endmodule // cmie_exec_monitor
bind cmie_exec cmie_exec_monitor mon_u (.i_mclk, .i_rst, .i_instr, .i_acc, .o_q, .o_fetch, .o_file_we, .o_file_wdata,
    .o_stack_pop, .o_pc_load, .o_irqc_we, .o_irqc_wdata, .o_option);
`default_nettype wire

// ---- testbench.sv ----
// Directed testbench for the instruction execution block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_mclk = 0;
    logic i_rst = 1;
    logic [13:0] i_instr = 0;
    logic [7:0] i_acc = 0;
    logic [12:0] i_stack_top_entry = 13'h1234;
    logic [7:0] i_irq_control_reg = 8'h05;
    logic [3:0] o_q;
    logic o_file_we, o_stack_pop, o_irqc_we, o_status_we;
    logic o_fetch, o_pc_load, o_illegal;
    logic [6:0] o_file_addr;
    logic [7:0] o_file_wdata, o_irqc_wdata, o_option;
    logic [12:0] o_pc_value;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #20 i_mclk = ~i_mclk;
    cmie_exec dut_u (.i_mclk, .i_rst, .i_instr, .i_acc, .i_stack_top_entry, .i_irq_control_reg, .o_q, .o_fetch,
        .o_file_we, .o_file_addr, .o_file_wdata, .o_stack_pop, .o_pc_load, .o_pc_value, .o_irqc_we,
        .o_irqc_wdata, .o_option, .o_status_we, .o_illegal);
    task chk(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Offer one word at Q1, take it away once latched, return at the next
    // Q1 when the pulses of the Q4 edge show
    task op(input logic [13:0] w, input logic [7:0] a);
        while (o_q !== 4'h1) @(negedge i_mclk);
        i_instr = w;
        i_acc = a;
        @(negedge i_mclk);
        i_instr = 14'h0000;
        repeat (3) @(negedge i_mclk);
    endtask
    task t_option;
        chk("option", o_option, 8'hFF);
        op(14'h0062, 8'h5A);
        chk("option", o_option, 8'h5A);
        op(14'h0081, 8'hC3); // Direct write is the preferred path
        chk("option", o_option, 8'hC3);
    endtask
    // Every don't-care form of the no-op
    task t_nop;
        for (int k = 0; k < 4; k++) begin
            op(14'(k * 32), 8'h11);
            chk("file_we", o_file_we, 0);
            chk("option", o_option, 8'hC3);
            chk("status_we", o_status_we, 0);
            chk("illegal", o_illegal, 0);
        end
    endtask
    task t_move;
        op(14'h00A5, 8'h3C);
        chk("file_we", o_file_we, 1);
        chk("file_addr", o_file_addr, 7'h25);
        chk("file_wdata", o_file_wdata, 8'h3C);
        chk("fetch", o_fetch, 1);
        chk("illegal", o_illegal, 0);
    endtask
    // Enable bit at Q3, pop at Q4 with no fetch; a move offered in the
    // flush cycle must be dropped
    task t_return;
        while (o_q !== 4'h1) @(negedge i_mclk);
        i_instr = 14'h0009;
        repeat (3) @(negedge i_mclk);
        chk("irqc_we", o_irqc_we, 1);
        chk("irqc_wdata", o_irqc_wdata, 8'h85);
        i_instr = 14'h00A5;
        @(negedge i_mclk);
        chk("pop", o_stack_pop, 1);
        chk("pc_load", o_pc_load, 1);
        chk("pc_value", o_pc_value, 13'h1234);
        chk("fetch", o_fetch, 0);
        repeat (4) @(negedge i_mclk);
        chk("file_we", o_file_we, 0);
        chk("fetch", o_fetch, 1);
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 400) begin
            n_errors++;
            end_of_test;
        end
    end
    initial begin
        repeat (10) @(negedge i_mclk);
        i_rst = 0;
        t_option;
        t_nop;
        t_move;
        t_return;
        t_move;
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
